/* core/rpsc_i2c_slave.sv */
// Serial register port slave with auto-incrementing register pointer
`timescale 1ns/1ps

module rpsc_i2c_slave (
  input  wire logic            clock,    // System clock
  input  wire logic            rst_b,    // Async reset, active low
  input  wire logic            port_on,  // Port enabled
  input  wire logic            scl_in,   // Serial clock pin
  input  wire logic            sda_in,   // Serial data pin level
  output logic                 sda_out,  // Serial data drive level
  output logic                 sda_oe,   // Serial data pulls low
  output rpsc_pkg::rpsc_wr_t   wr,       // Register write
  output logic [7:0]           rd_addr,  // Register read pointer
  input  wire logic [7:0]      rd_data   // Register read data
);
  import rpsc_pkg::*;

  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_REG, SL_REG_ACK,
    SL_WDATA, SL_WDATA_ACK, SL_RDATA
  } rpsc_sl_state_t;

  typedef struct packed {
    logic [1:0]     scl_sync;
    logic [1:0]     sda_sync;
    logic           scl_d;
    logic           sda_d;
    rpsc_sl_state_t st;
    logic [3:0]     cnt;
    logic [7:0]     shift;
    logic           rw;
    logic [7:0]     ptr;
    logic           oe;
    logic           rd_ack_wait;
    rpsc_wr_t       wr;
  } rpsc_sl_t;

  rpsc_sl_t s;
  rpsc_sl_t next_s;

  always_comb begin
    logic       scl;
    logic       sda;
    logic [7:0] sh;
    scl = s.scl_sync[1];
    sda = s.sda_sync[1];
    sh = s.shift << s.cnt[2:0];
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], scl_in};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.scl_d = scl;
    next_s.sda_d = sda;
    next_s.wr.wr_strobe = 1'b0;
    if (!port_on) begin
      next_s.st = SL_IDLE;
      next_s.oe = 1'b0;
    end else if (scl && s.scl_d && s.sda_d && !sda) begin
      // Start or repeated start
      next_s.st = SL_ADDR;
      next_s.cnt = 4'h0;
      next_s.oe = 1'b0;
      next_s.rd_ack_wait = 1'b0;
    end else if (scl && s.scl_d && !s.sda_d && sda) begin
      next_s.st = SL_IDLE;
      next_s.oe = 1'b0;
    end else if (scl && !s.scl_d) begin
      if (s.rd_ack_wait) begin
        next_s.rd_ack_wait = 1'b0;
        next_s.cnt = 4'h0;
        next_s.shift = rd_data;
        next_s.st = sda ? SL_IDLE : SL_RDATA;
      end else if (s.st == SL_ADDR || s.st == SL_REG
                   || s.st == SL_WDATA || s.st == SL_RDATA) begin
        if (s.st != SL_RDATA) begin
          next_s.shift = {s.shift[6:0], sda};
        end
        next_s.cnt = s.cnt + 4'h1;
      end
    end else if (!scl && s.scl_d) begin
      unique case (s.st)
        SL_IDLE: begin
        end
        SL_ADDR: begin
          if (s.cnt == 4'h8) begin
            if (s.shift[7:1] == I2C_DEV_ADDR) begin
              next_s.oe = 1'b1;
              next_s.rw = s.shift[0];
              next_s.st = SL_ADDR_ACK;
            end else begin
              next_s.st = SL_IDLE;
            end
          end
        end
        SL_ADDR_ACK: begin
          next_s.cnt = 4'h0;
          if (s.rw) begin
            next_s.shift = rd_data;
            next_s.oe = !rd_data[7];
            next_s.st = SL_RDATA;
          end else begin
            next_s.oe = 1'b0;
            next_s.st = SL_REG;
          end
        end
        SL_REG: begin
          if (s.cnt == 4'h8) begin
            next_s.oe = 1'b1;
            next_s.ptr = s.shift;
            next_s.st = SL_REG_ACK;
          end
        end
        SL_REG_ACK, SL_WDATA_ACK: begin
          next_s.oe = 1'b0;
          next_s.cnt = 4'h0;
          next_s.st = SL_WDATA;
          if (s.st == SL_WDATA_ACK) begin
            next_s.ptr = s.ptr + 8'h01;
          end
        end
        SL_WDATA: begin
          if (s.cnt == 4'h8) begin
            next_s.oe = 1'b1;
            next_s.wr.wr_strobe = 1'b1;
            next_s.wr.wr_addr = s.ptr;
            next_s.wr.wr_data = s.shift;
            next_s.st = SL_WDATA_ACK;
          end
        end
        SL_RDATA: begin
          if (s.cnt == 4'h8) begin
            // Release for the master's acknowledge
            next_s.oe = 1'b0;
            next_s.ptr = s.ptr + 8'h01;
            next_s.rd_ack_wait = 1'b1;
          end else if (!s.rd_ack_wait) begin
            next_s.oe = !sh[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
             st: SL_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = s.oe;
  assign wr      = s.wr;
  assign rd_addr = s.ptr;

endmodule // rpsc_i2c_slave

/* core/rpsc_pkg.sv */
// Package: register map, field layout, codes and timing for power state control
package rpsc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] REG_POWER_DOWN  = 8'h09;
  localparam logic [7:0] REG_CLOCK_RATIO = 8'h0A;
  localparam logic [7:0] REG_TX_TERM     = 8'h0B;
  localparam logic [7:0] REG_SWING_EMPH  = 8'h0C;
  localparam logic [7:0] REG_STATUS      = 8'h20;

  // ==========================================================================
  // Field positions and reset values
  localparam int         POWER_DOWN_BIT  = 3;
  localparam int         CLOCK_RATIO_BIT = 1;
  localparam int         TX_TERM_LSB     = 3;
  localparam int         SWING_LSB       = 2;
  localparam int         EMPH_LSB        = 0;
  localparam int         STAT_PD_BIT     = 7;
  localparam int         STAT_SB_BIT     = 6;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [5:0] SWING_NOMINAL   = 6'h00;

  // ==========================================================================
  // Codes
  localparam logic [1:0] EMPH_MINUS_2DB  = 2'h1;
  localparam logic [1:0] EMPH_NONE       = 2'h0;
  localparam logic [1:0] TERM_NONE       = 2'h0;
  localparam logic [1:0] TERM_150_300    = 2'h1;
  localparam logic [1:0] TERM_75_150     = 2'h3;
  localparam logic [1:0] STRAP_LOW       = 2'h0;
  localparam logic [1:0] STRAP_FLOAT     = 2'h1;
  localparam logic [1:0] STRAP_HIGH      = 2'h2;
  // Arbitrary serial port device address
  localparam logic [6:0] I2C_DEV_ADDR    = 7'h2A;

  // ==========================================================================
  // Timing
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         CLK_LOSS_NS     = 1000;
  localparam int         CLK_LOSS_CYCLES = CLK_LOSS_NS / CLK_PERIOD_NS;
  localparam logic [2:0] CLK_VALID_EDGES = 3'h4;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PS_POWER_DOWN,
    PS_STANDBY,
    PS_NORMAL
  } rpsc_state_t;

  typedef struct packed {
    logic [2:0] data_lanes_in_enable;
    logic       rx_termination_on;
    logic       clock_lane_active;
    logic       data_lanes_out_enable;
    logic       cdr_enable;
    logic       retimer_mode;
    logic       display_control_channel_enable;
    logic       audio_return_path_enable;
  } rpsc_lanes_t;

  typedef struct packed {
    logic [5:0] swing_adjust;
    logic [1:0] emphasis_code_field;
    logic [1:0] tx_term_code;
    logic       pll_high_rate;
  } rpsc_drive_t;

  typedef struct packed {
    logic       wr_strobe;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } rpsc_wr_t;

endpackage

/* core/rpsc_power_state_control.sv */
// Operating-state control: power modes, hot-plug, registers and drive setup
`timescale 1ns/1ps

// Summary of operation
// [R01] Enable low: lowest power, power-down with serial port off
// [R02] Enable rising edge resets device and registers
// [R03] Power-down bit forces power-down
// [R04] Sink hot-plug low keeps power-down
// [R05] Hot-plug high without clock: standby; with the detector disabled, normal
// [R06] Standby: data lanes off, clock lane on
// [R07] Hot-plug: enable outputs, recovery per detection
// [R08] Source hot-plug follows sink hot-plug always
// [R09] Power-down entry clears the registers; a forcing power-down bit stays set
// [R10] Source rewrites clock-ratio flag after power-down
// [R11] Swing adjust from register bits 7:2
// [R12] Emphasis code from register bits 1:0
// [R13] Termination code from register bits 4:3
// [R14] Emphasis strap low selects minus 2 dB
// [R15] Floating termination strap selects automatically
// [R16] Power-down: termination on, outputs off
// [R17] Valid clock during hot-plug: normal operation
module rpsc_power_state_control (
  input  wire logic          clock,                  // 40 MHz clock
  input  wire logic          rst_b,                  // Async reset, low
  input  wire logic          enable_pin,             // Device enable pin
  input  wire logic          sink_hotplug_in,        // Sink hot-plug
  input  wire logic          link_clock_in,          // Incoming clock lane
  input  wire logic          signal_detect_control,  // Detector enable pin
  input  wire logic          config_by_straps,       // Strap config mode
  input  wire logic          emphasis_select_pin,    // Emphasis strap
  input  wire logic [1:0]    termination_select_pin, // Term strap level
  input  wire logic          scl_in,                 // Serial clock
  input  wire logic          sda_in,                 // Serial data in
  output logic               sda_out,                // Serial data out
  output logic               sda_oe,                 // Serial data enable
  output logic               source_hotplug_out,     // Source hot-plug
  output rpsc_pkg::rpsc_lanes_t lanes,               // Lane controls
  output rpsc_pkg::rpsc_drive_t drive,               // Output drive setup
  output rpsc_pkg::rpsc_state_t power_state,         // Operating state
  output logic               i2c_port_active         // Serial port on
);
  import rpsc_pkg::*;

  typedef struct packed {
    logic [1:0]  en_sync;
    logic [1:0]  hpd_sync;
    logic [1:0]  lclk_sync;
    logic [1:0]  sig_sync;
    logic [1:0]  strap_sync;
    logic [1:0]  emph_sync;
    logic [3:0]  term_sync;
    logic        en_d;
    logic        lclk_d;
    logic [7:0]  gap;
    logic [2:0]  edges;
    rpsc_state_t st;
    logic [7:0]  reg_pd;
    logic [7:0]  reg_ratio;
    logic [7:0]  reg_term;
    logic [7:0]  reg_swing;
    logic        hpd_out;
    rpsc_lanes_t lanes;
    rpsc_drive_t drive;
    logic        port_on;
  } rpsc_top_t;

  rpsc_top_t s;
  rpsc_top_t next_s;
  rpsc_wr_t  wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  // ==========================================================================
  // Serial register port
  rpsc_i2c_slave u_i2c (
    .clock   (clock),
    .rst_b   (rst_b),
    .port_on (s.port_on),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr      (wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  always_comb begin
    rd_data = REG_RESET;
    unique case (rd_addr)
      REG_POWER_DOWN:  rd_data = s.reg_pd;
      REG_CLOCK_RATIO: rd_data = s.reg_ratio;
      REG_TX_TERM:     rd_data = s.reg_term;
      REG_SWING_EMPH:  rd_data = s.reg_swing;
      REG_STATUS: begin
        rd_data[STAT_PD_BIT] = (s.st == PS_POWER_DOWN);
        rd_data[STAT_SB_BIT] = (s.st == PS_STANDBY);
      end
      default:         rd_data = REG_RESET;
    endcase
  end

  // ==========================================================================
  // State update
  always_comb begin
    logic en;
    logic hpd;
    logic clk_valid;
    logic ratio;
    next_s = s;
    next_s.en_sync    = {s.en_sync[0], enable_pin};
    next_s.hpd_sync   = {s.hpd_sync[0], sink_hotplug_in};
    next_s.lclk_sync  = {s.lclk_sync[0], link_clock_in};
    next_s.sig_sync   = {s.sig_sync[0], signal_detect_control};
    next_s.strap_sync = {s.strap_sync[0], config_by_straps};
    next_s.emph_sync  = {s.emph_sync[0], emphasis_select_pin};
    next_s.term_sync  = {s.term_sync[1:0], termination_select_pin};
    en  = s.en_sync[1];
    hpd = s.hpd_sync[1];
    next_s.en_d   = en;
    next_s.lclk_d = s.lclk_sync[1];
    next_s.hpd_out = hpd;                                       // [R08]

    // Clock lane detection from sampled edges
    if (s.lclk_sync[1] && !s.lclk_d) begin
      next_s.gap = 8'h00;
      if (s.edges != CLK_VALID_EDGES) begin
        next_s.edges = s.edges + 3'h1;
      end
    end else if (s.gap >= 8'(CLK_LOSS_CYCLES)) begin
      next_s.edges = 3'h0;
    end else begin
      next_s.gap = s.gap + 8'h01;
    end
    clk_valid = (s.edges == CLK_VALID_EDGES);

    // Register writes
    if (wr.wr_strobe) begin
      unique case (wr.wr_addr)
        REG_POWER_DOWN:  next_s.reg_pd    = wr.wr_data;
        REG_CLOCK_RATIO: next_s.reg_ratio = wr.wr_data;
        REG_TX_TERM:     next_s.reg_term  = wr.wr_data;
        REG_SWING_EMPH:  next_s.reg_swing = wr.wr_data;
        default: begin
        end
      endcase
    end

    // Operating state
    if (!en) begin
      next_s.st = PS_POWER_DOWN;                                // [R01]
    end else if (next_s.reg_pd[POWER_DOWN_BIT]) begin
      next_s.st = PS_POWER_DOWN;                                // [R03]
    end else if (!hpd) begin
      next_s.st = PS_POWER_DOWN;                                // [R04]
    end else if (clk_valid || !s.sig_sync[1]) begin
      next_s.st = PS_NORMAL;                                    // [R17]
    end else begin
      next_s.st = PS_STANDBY;                                   // [R05]
    end

    // Register clearing; a forcing power-down bit survives its own entry
    if (!en || (en && !s.en_d)) begin
      next_s.reg_pd    = REG_RESET;                             // [R02]
      next_s.reg_ratio = REG_RESET;
      next_s.reg_term  = REG_RESET;
      next_s.reg_swing = REG_RESET;
      next_s.edges     = 3'h0;
      next_s.gap       = 8'h00;
    end else if (next_s.st == PS_POWER_DOWN && s.st != PS_POWER_DOWN) begin
      next_s.reg_pd    = next_s.reg_pd & (8'h01 << POWER_DOWN_BIT); // [R09]
      next_s.reg_ratio = REG_RESET;                             // [R09]
      next_s.reg_term  = REG_RESET;
      next_s.reg_swing = REG_RESET;
    end
    next_s.port_on = en;                                        // [R01]

    // Lane controls per state
    next_s.lanes = '0;
    next_s.lanes.rx_termination_on = 1'b1;                      // [R16]
    unique case (next_s.st)
      PS_POWER_DOWN: begin
      end
      PS_STANDBY: begin
        next_s.lanes.clock_lane_active = 1'b1;                  // [R06]
        next_s.lanes.display_control_channel_enable = 1'b1;     // [R06]
        next_s.lanes.audio_return_path_enable = 1'b1;           // [R06]
      end
      PS_NORMAL: begin
        next_s.lanes.data_lanes_in_enable = 3'h7;
        next_s.lanes.clock_lane_active = 1'b1;
        next_s.lanes.data_lanes_out_enable = 1'b1;              // [R07]
        next_s.lanes.cdr_enable = clk_valid && s.sig_sync[1];   // [R07]
        next_s.lanes.retimer_mode = clk_valid && s.sig_sync[1]; // [R07]
        next_s.lanes.display_control_channel_enable = 1'b1;
        next_s.lanes.audio_return_path_enable = 1'b1;
      end
    endcase

    // Drive setup from registers or straps
    ratio = next_s.reg_ratio[CLOCK_RATIO_BIT];
    next_s.drive.pll_high_rate = ratio;                         // [R10]
    if (s.strap_sync[1]) begin
      next_s.drive.swing_adjust = SWING_NOMINAL;
      next_s.drive.emphasis_code_field =
        s.emph_sync[1] ? EMPH_NONE : EMPH_MINUS_2DB;            // [R14]
      unique case (s.term_sync[3:2])
        STRAP_LOW:  next_s.drive.tx_term_code = TERM_NONE;
        STRAP_HIGH: next_s.drive.tx_term_code = TERM_75_150;
        default:    next_s.drive.tx_term_code =
                      ratio ? TERM_75_150 : TERM_NONE;          // [R15]
      endcase
    end else begin
      next_s.drive.swing_adjust = next_s.reg_swing[SWING_LSB +: 6];    // [R11]
      next_s.drive.emphasis_code_field =
        next_s.reg_swing[EMPH_LSB +: 2];                        // [R12]
      next_s.drive.tx_term_code = next_s.reg_term[TX_TERM_LSB +: 2];   // [R13]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{st: PS_POWER_DOWN, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign source_hotplug_out = s.hpd_out;
  assign lanes              = s.lanes;
  assign drive              = s.drive;
  assign power_state        = s.st;
  assign i2c_port_active    = s.port_on;

endmodule // rpsc_power_state_control

/* testbench/rpsc_chk.sv */
// Checker: port properties of the power state controller
`timescale 1ns/1ps

module rpsc_chk (
  input wire logic                  clock,                  // Clock
  input wire logic                  rst_b,                  // Reset
  input wire logic                  enable_pin,             // Enable
  input wire logic                  sink_hotplug_in,        // Sink HP
  input wire logic                  link_clock_in,          // Clock lane
  input wire logic                  signal_detect_control,  // Detector
  input wire logic                  config_by_straps,       // Strap mode
  input wire logic                  emphasis_select_pin,    // Emph strap
  input wire logic [1:0]            termination_select_pin, // Term strap
  input wire logic                  source_hotplug_out,     // Source HP
  input wire rpsc_pkg::rpsc_lanes_t lanes,                  // Lanes
  input wire rpsc_pkg::rpsc_drive_t drive,                  // Drive
  input wire rpsc_pkg::rpsc_state_t power_state,            // State
  input wire logic                  i2c_port_active         // Port on
);
  import rpsc_pkg::*;
  logic       lk_q;
  logic [6:0] gap;
  logic [2:0] n_ok;
  logic       ck_ok;
  logic       ck_dead;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ========
  // Clock lane watch: edges with short gaps make a valid clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lk_q <= 1'b0;
      gap  <= 7'h7F;
      n_ok <= 3'h0;
    end else begin
      lk_q <= link_clock_in;
      if (link_clock_in && !lk_q) begin
        gap  <= 7'h00;
        n_ok <= (gap > 7'h28) ? 3'h1 : ((n_ok == 3'h7) ? n_ok : n_ok + 3'h1);
      end else if (gap != 7'h7F) begin
        gap <= gap + 7'h01;
      end
    end
  end
  assign ck_ok   = (n_ok >= 3'h6) && (gap < 7'h1E);
  assign ck_dead = gap > 7'h3C;

  // ========
  // Properties
  sequence s_hot_clk;
    enable_pin && sink_hotplug_in && ck_ok;
  endsequence
  sequence s_hot_dead;
    enable_pin && sink_hotplug_in && signal_detect_control && ck_dead;
  endsequence

  a_hp_follow: assert property (
    $stable(sink_hotplug_in)[*6] |-> source_hotplug_out == sink_hotplug_in)
    else $error("source hot-plug differs from sink hot-plug");
  a_off_lanes: assert property (
    !enable_pin[*8] |-> power_state == PS_POWER_DOWN && lanes == 10'h040
      && !i2c_port_active) else $error("enable low not fully off");
  a_hp_low_pd: assert property (
    (enable_pin && !sink_hotplug_in)[*8] |-> power_state == PS_POWER_DOWN
      && i2c_port_active) else $error("hot-plug low not power-down");
  a_pd_lanes: assert property (
    power_state == PS_POWER_DOWN[*4] |-> lanes == 10'h040)
    else $error("power-down lane controls wrong");
  a_sb_lanes: assert property (
    power_state == PS_STANDBY[*4] |-> lanes == 10'h063)
    else $error("standby lane controls wrong");
  a_run_lanes: assert property (
    power_state == PS_NORMAL[*4] |-> (lanes | 10'h00C) == 10'h3FF
      && lanes.cdr_enable == lanes.retimer_mode)
    else $error("normal lane controls wrong");
  a_clk_run: assert property (
    s_hot_clk[*8] |-> power_state != PS_STANDBY)
    else $error("valid clock left in standby");
  a_no_clk: assert property (
    s_hot_dead[*8] |-> power_state != PS_NORMAL)
    else $error("normal without a valid clock");
  a_strap_emph: assert property (
    (enable_pin && config_by_straps && !emphasis_select_pin)[*6]
      |-> drive.emphasis_code_field == EMPH_MINUS_2DB)
    else $error("strap low emphasis wrong");
  a_auto_term: assert property (
    (enable_pin && config_by_straps && $stable(drive.pll_high_rate)
      && termination_select_pin == STRAP_FLOAT)[*6]
      |-> drive.tx_term_code == (drive.pll_high_rate ? TERM_75_150 : TERM_NONE))
    else $error("automatic termination wrong");
  a_en_rise: assert property (
    $rose(enable_pin) && !config_by_straps |-> ##6 drive == 11'h000)
    else $error("enable rise did not clear setup");
  a_pd_clear: assert property (
    $changed(power_state) && power_state == PS_POWER_DOWN && !config_by_straps
      |-> ##[1:4] drive == 11'h000) else $error("power-down did not clear");
endmodule // rpsc_chk

bind rpsc_power_state_control rpsc_chk chk_u (
  .clock(clock), .rst_b(rst_b), .enable_pin(enable_pin),
  .sink_hotplug_in(sink_hotplug_in), .link_clock_in(link_clock_in),
  .signal_detect_control(signal_detect_control),
  .config_by_straps(config_by_straps),
  .emphasis_select_pin(emphasis_select_pin),
  .termination_select_pin(termination_select_pin),
  .source_hotplug_out(source_hotplug_out), .lanes(lanes), .drive(drive),
  .power_state(power_state), .i2c_port_active(i2c_port_active)
);

/* testbench/rpsc_partner.sv */
// Link partner model: sink hot-plug and incoming clock lane
`timescale 1ns/1ps

module rpsc_partner (
  input  wire logic       hp_req,          // Hot-plug wanted
  input  wire logic [1:0] ck_mode,         // 0 still, 1 fast, 2 slow
  output logic            sink_hotplug_in, // Sink hot-plug
  output logic            link_clock_in    // Clock lane
);
  logic lk;
  // ========
  // Clock lane stands low outside frames
  assign #37 sink_hotplug_in = hp_req;
  // Offset keeps lane edges clear of the sampling clock edge
  assign #7 link_clock_in = lk;
  initial lk = 1'b0;
  always begin
    if (ck_mode == 2'h1) #100 lk = !lk;
    else if (ck_mode == 2'h2) #1000 lk = !lk;
    else #100 lk = 1'b0;
  end
endmodule // rpsc_partner

/* testbench/tb_top.sv */
// Testbench: register port sequences for the power state controller
`timescale 1ns/1ps

module tb_top;
  import rpsc_pkg::*;
  logic        clock;
  logic        rst_b;
  logic        enable_pin;
  logic        hp_req;
  logic [1:0]  ck_mode;
  logic        signal_detect_control;
  logic        config_by_straps;
  logic        emphasis_select_pin;
  logic [1:0]  termination_select_pin;
  logic        m_scl;
  logic        m_sda;
  logic        ak;
  logic [7:0]  rd;
  wire         sink_hotplug_in;
  wire         link_clock_in;
  wire         sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic        source_hotplug_out;
  logic        i2c_port_active;
  rpsc_lanes_t lanes;
  rpsc_drive_t drive;
  rpsc_state_t power_state;
  int          num_errors;
  int          checks_done;
  logic [7:0]  regs [4];
  logic [1:0]  terms [3];

  always #12.5 clock = ~clock;
  // Open-drain data line with pull-up
  assign sda_line = m_sda & ~(sda_oe & ~sda_out);

  rpsc_partner link_u (.hp_req(hp_req), .ck_mode(ck_mode),
    .sink_hotplug_in(sink_hotplug_in), .link_clock_in(link_clock_in));
  rpsc_power_state_control dut_u (
    .clock(clock), .rst_b(rst_b), .enable_pin(enable_pin),
    .sink_hotplug_in(sink_hotplug_in), .link_clock_in(link_clock_in),
    .signal_detect_control(signal_detect_control),
    .config_by_straps(config_by_straps),
    .emphasis_select_pin(emphasis_select_pin),
    .termination_select_pin(termination_select_pin),
    .scl_in(m_scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .source_hotplug_out(source_hotplug_out), .lanes(lanes), .drive(drive),
    .power_state(power_state), .i2c_port_active(i2c_port_active));

  // ========
  // Tasks
  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks_done++;
    if (seen !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, seen);
    end
  endtask
  task close_out;
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge clock);
  endtask
  // One serial bit; the line is sampled while the clock is high
  task bit_io(input logic b);
    m_sda = b;
    step(4);
    m_scl = 1'b1;
    step(4);
    ak = sda_line;
    m_scl = 1'b0;
  endtask
  task start;
    m_sda = 1'b1;
    step(4);
    m_scl = 1'b1;
    step(4);
    m_sda = 1'b0;
    step(4);
    m_scl = 1'b0;
  endtask
  task stop;
    m_sda = 1'b0;
    step(4);
    m_scl = 1'b1;
    step(4);
    m_sda = 1'b1;
    step(4);
  endtask
  task put(input logic [7:0] b, input logic ack_ex);
    for (int i = 7; i >= 0; i--) bit_io(b[i]);
    bit_io(1'b1);
    check("ack", !ak, ack_ex);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    start;
    put({I2C_DEV_ADDR, 1'b0}, 1'b1);
    put(a, 1'b1);
    put(d, 1'b1);
    stop;
    step(2);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] ex);
    start;
    put({I2C_DEV_ADDR, 1'b0}, 1'b1);
    put(a, 1'b1);
    start;
    put({I2C_DEV_ADDR, 1'b1}, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1);
      rd[i] = ak;
    end
    bit_io(1'b1);
    stop;
    check("register", rd, ex);
  endtask
  task wait_st(input rpsc_state_t s);
    int n;
    n = 0;
    while (power_state !== s && n < 400) begin
      step(1);
      n++;
    end
    check("power_state", power_state, s);
    if (power_state !== s) close_out;
    step(6);
  endtask

  // ========
  // Main sequence
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    enable_pin = 1'b0;
    hp_req = 1'b1;
    ck_mode = 2'h0;
    signal_detect_control = 1'b1;
    config_by_straps = 1'b0;
    emphasis_select_pin = 1'b1;
    termination_select_pin = STRAP_LOW;
    m_scl = 1'b1;
    m_sda = 1'b1;
    num_errors = 0;
    checks_done = 0;
    regs = '{REG_POWER_DOWN, REG_CLOCK_RATIO, REG_TX_TERM, REG_SWING_EMPH};
    terms = '{TERM_NONE, TERM_150_300, TERM_75_150};
    repeat (12) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    step(10);
    check("lanes", lanes, 10'h040);
    check("port", i2c_port_active, 1'b0);
    check("hp_out", source_hotplug_out, 1'b1);
    start;
    put({I2C_DEV_ADDR, 1'b0}, 1'b0);
    stop;
    hp_req = 1'b0;
    enable_pin = 1'b1;
    wait_st(PS_POWER_DOWN);
    check("port", i2c_port_active, 1'b1);
    check("hp_out", source_hotplug_out, 1'b0);
    foreach (regs[i]) rd_chk(regs[i], REG_RESET);
    wr(8'h30, 8'h5A);
    rd_chk(8'h30, 8'h00);
    start;
    put(8'h2A, 1'b0);
    stop;
    hp_req = 1'b1;
    wait_st(PS_STANDBY);
    check("lanes", lanes, 10'h063);
    rd_chk(REG_STATUS, 8'h40);
    ck_mode = 2'h1;
    wait_st(PS_NORMAL);
    check("lanes", lanes, 10'h3FF);
    rd_chk(REG_STATUS, 8'h00);
    wr(REG_SWING_EMPH, 8'hA5);
    check("swing", drive.swing_adjust, 6'h29);
    check("emph", drive.emphasis_code_field, EMPH_MINUS_2DB);
    foreach (terms[i]) begin
      wr(REG_TX_TERM, {3'h0, terms[i], 3'h0});
      check("term", drive.tx_term_code, terms[i]);
    end
    wr(REG_CLOCK_RATIO, 8'h02);
    check("pll", drive.pll_high_rate, 1'b1);
    wr(REG_POWER_DOWN, 8'h08);
    wait_st(PS_POWER_DOWN);
    check("lanes", lanes, 10'h040);
    check("drive", drive, 11'h000);
    rd_chk(REG_CLOCK_RATIO, 8'h00);
    rd_chk(REG_STATUS, 8'h80);
    wr(REG_POWER_DOWN, 8'h00);
    wait_st(PS_NORMAL);
    wr(REG_CLOCK_RATIO, 8'h02);
    check("pll", drive.pll_high_rate, 1'b1);
    ck_mode = 2'h2;
    wait_st(PS_STANDBY);
    signal_detect_control = 1'b0;
    wait_st(PS_NORMAL);
    check("lanes", lanes, 10'h3F3);
    signal_detect_control = 1'b1;
    ck_mode = 2'h0;
    hp_req = 1'b0;
    wait_st(PS_POWER_DOWN);
    check("hp_out", source_hotplug_out, 1'b0);
    config_by_straps = 1'b1;
    emphasis_select_pin = 1'b0;
    step(8);
    check("emph", drive.emphasis_code_field, EMPH_MINUS_2DB);
    emphasis_select_pin = 1'b1;
    wr(REG_CLOCK_RATIO, 8'h02);
    termination_select_pin = STRAP_FLOAT;
    step(8);
    check("emph", drive.emphasis_code_field, EMPH_NONE);
    check("term", drive.tx_term_code, TERM_75_150);
    termination_select_pin = STRAP_HIGH;
    step(8);
    check("term", drive.tx_term_code, TERM_75_150);
    config_by_straps = 1'b0;
    wr(REG_SWING_EMPH, 8'hFC);
    enable_pin = 1'b0;
    step(10);
    check("lanes", lanes, 10'h040);
    check("port", i2c_port_active, 1'b0);
    enable_pin = 1'b1;
    step(10);
    check("drive", drive, 11'h000);
    rd_chk(REG_SWING_EMPH, 8'h00);
    close_out;
  end
endmodule // tb_top
